// ---- include/hc_port_pkg.sv ----
// Purpose: Constants and carriers for the root-hub port and descriptor map registers
// Assumes: AXI4-Lite slave, 32-bit data, 50 MHz aclk
// Notes:   Offsets 0xa6, 0xaa are not word aligned, so printed offsets are indices
//
// Functional notes
// - Port word reset only by controller reset
// - Port state writes ignored until power set
// - Test select nonzero means test mode
// - Owner clears on flag rise, set when clear
// - Port power bit enables the root hub
// - Line state mirrors DP and DM levels
// - Bus reset bit starts and ends reset
// - Suspend bit reads port suspend state
// - Force resume reads K-state present
// - Enable bit shows port enabled
// - Connect change set on presence change
// - Connect present shows attached peripheral
// - Status bits 0 to 8 read zero without power; line state still reads
// - Done bit set when descriptor completes
// - Done map read clears bits read
// - Skip bit blocks descriptor processing
// - Last bit ends scan then wraps
// - Last map resets to zero
package hc_port_pkg;
  localparam logic [7:0]  IDX_PORT_STATUS_CONTROL = 8'ha0;
  localparam logic [7:0]  IDX_ISO_DONE_MAP        = 8'ha4;
  localparam logic [7:0]  IDX_ISO_SKIP_MAP        = 8'ha6;
  localparam logic [7:0]  IDX_ISO_LAST_MAP        = 8'ha8;
  localparam logic [7:0]  IDX_INTERRUPT_DONE_MAP  = 8'haa;
  localparam logic [7:0]  IDX_CONFIGURE_FLAG_REG  = 8'hb8;
  localparam logic [7:0]  IDX_SCAN_STATUS         = 8'hb9;
  localparam int          ADDR_W                  = 10;
  localparam int          POS_CONNECT_PRESENT     = 0;
  localparam int          POS_CONNECT_CHANGE      = 1;
  localparam int          POS_PORT_ENABLE         = 2;
  localparam int          POS_FORCE_RESUME        = 6;
  localparam int          POS_PORT_SUSPENDED      = 7;
  localparam int          POS_BUS_RESET_DRIVE     = 8;
  localparam int          POS_LINE_STATE_DM       = 10;
  localparam int          POS_LINE_STATE_DP       = 11;
  localparam int          POS_PORT_POWER_ON       = 12;
  localparam int          POS_HANDOFF_OWNER       = 13;
  localparam int          POS_TEST_SELECT_LO      = 16;
  localparam logic [15:0] RESET_DONE_MAP          = 16'h0000;
  localparam logic [15:0] RESET_SKIP_MAP          = 16'hffff;
  localparam logic [15:0] RESET_LAST_MAP          = 16'h0000;
  localparam logic [3:0]  RESET_TEST_SELECT       = 4'h0;
  localparam int          CLK_HZ                  = 50000000;
  localparam int          POWER_SETTLE_MS         = 20;
  localparam int          SKIP_READBACK_NS        = 100;
  localparam int          SKIP_READBACK_CYCLES    = (SKIP_READBACK_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [1:0]  RESP_OKAY               = 2'h0;
  localparam logic [1:0]  RESP_SLVERR             = 2'h2;

  typedef struct packed {
    logic [3:0] test_select;
    logic       handoff_owner;
    logic       port_power_on;
    logic       bus_reset_drive;
    logic       port_suspended;
    logic       force_resume_sw;
    logic       port_enable;
    logic       connect_change;
  } port_ctrl_type;

  typedef struct packed {
    logic       connect;
    logic       suspended;
    logic       resume_k;
    logic       enabled;
    logic       dp;
    logic       dm;
  } port_pins_type;
endpackage

// ---- src/hc_port_regs.sv ----
// Purpose: Root-hub port status word and descriptor map registers over AXI4-Lite
// Assumes: Pins from the port PHY are asynchronous; engine signals share aclk
// Notes:   Byte address = 4 * index; reads and writes answer in one cycle
`timescale 1ns/1ps
`default_nettype none
module hc_port_regs #(
  parameter int NUM_DESC = 16
) (
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  input  wire logic                              clk_en,
  input  wire logic [hc_port_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output var  logic                              s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output var  logic                              s_axi_wready,
  output var  logic [1:0]                        s_axi_bresp,
  output var  logic                              s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [hc_port_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output var  logic                              s_axi_arready,
  output var  logic [31:0]                       s_axi_rdata,
  output var  logic [1:0]                        s_axi_rresp,
  output var  logic                              s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  input  wire hc_port_pkg::port_pins_type        port_pins,
  input  wire logic [NUM_DESC-1:0]               iso_valid,
  input  wire logic [NUM_DESC-1:0]               iso_complete,
  input  wire logic [NUM_DESC-1:0]               int_complete,
  input  wire logic                              iso_scan_step,
  output var  logic                              root_hub_enable,
  output var  logic                              bus_reset_out,
  output var  logic [3:0]                        test_mode,
  output var  logic                              handoff_owner_out,
  output var  logic                              iso_process,
  output var  logic [3:0]                        iso_process_index
);
  hc_port_pkg::port_pins_type pins_meta_q, pins_q, pins_prev_q;
  hc_port_pkg::port_ctrl_type ctrl_q;
  logic [NUM_DESC-1:0] iso_done_q, iso_skip_q, iso_last_q, int_done_q;
  logic                cfg_flag_q;
  logic [3:0]          scan_idx_q;
  logic                aw_hold_q, w_hold_q;
  logic [hc_port_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;
  logic                wr_fire, rd_fire, wr_known, rd_known;
  logic [7:0]          wr_idx, rd_idx;
  logic [31:0]         rd_word, port_word;
  logic [31:0]         wmask;
  logic [31:0]         wval;
  logic                pwr;

  // Two-stage synchroniser on the PHY line levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_meta_q <= '0;
      pins_q      <= '0;
      pins_prev_q <= '0;
    end else if (clk_en) begin
      pins_meta_q <= port_pins;
      pins_q      <= pins_meta_q;
      pins_prev_q <= pins_q;
    end
  end

  // Write channel: address and data may arrive in either order
  assign wr_fire = (aw_hold_q || s_axi_awvalid) && (w_hold_q || s_axi_wvalid) && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= hc_port_pkg::RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? hc_port_pkg::RESP_OKAY : hc_port_pkg::RESP_SLVERR;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
      end else begin
        // Ready follows the next hold and response state, so it leaves a flop
        s_axi_awready <= !(aw_hold_q || (s_axi_awvalid && s_axi_awready)) && !(s_axi_bvalid && !s_axi_bready);
        s_axi_wready  <= !(w_hold_q || (s_axi_wvalid && s_axi_wready)) && !(s_axi_bvalid && !s_axi_bready);
        if (s_axi_bready) s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_idx = aw_hold_q ? awaddr_q[9:2] : s_axi_awaddr[9:2];
    wval   = w_hold_q ? wdata_q : s_axi_wdata;
    wmask  = w_hold_q ? {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}}
                      : {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    wval   = wval & wmask;
    wr_known = (wr_idx == hc_port_pkg::IDX_PORT_STATUS_CONTROL) || (wr_idx == hc_port_pkg::IDX_ISO_DONE_MAP)
            || (wr_idx == hc_port_pkg::IDX_ISO_SKIP_MAP) || (wr_idx == hc_port_pkg::IDX_ISO_LAST_MAP)
            || (wr_idx == hc_port_pkg::IDX_INTERRUPT_DONE_MAP) || (wr_idx == hc_port_pkg::IDX_CONFIGURE_FLAG_REG)
            || (wr_idx == hc_port_pkg::IDX_SCAN_STATUS);
  end

  // Configure flag; the handoff owner follows it in the port control word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_flag_q <= 1'b0;
    end else if (clk_en && wr_fire && wr_idx == hc_port_pkg::IDX_CONFIGURE_FLAG_REG && wmask[0]) begin
      cfg_flag_q <= wval[0];
    end
  end

  assign pwr = ctrl_q.port_power_on;
  // Port control word; only the controller reset clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= '{test_select: hc_port_pkg::RESET_TEST_SELECT, handoff_owner: 1'b1, default: 1'b0};
    end else if (clk_en) begin
      if (!cfg_flag_q) ctrl_q.handoff_owner <= 1'b1;
      else if (wr_fire && wr_idx == hc_port_pkg::IDX_CONFIGURE_FLAG_REG && wmask[0] && !wval[0])
        ctrl_q.handoff_owner <= 1'b1;
      if (wr_fire && wr_idx == hc_port_pkg::IDX_CONFIGURE_FLAG_REG && wmask[0] && wval[0] && !cfg_flag_q)
        ctrl_q.handoff_owner <= 1'b0;
      if (wr_fire && wr_idx == hc_port_pkg::IDX_PORT_STATUS_CONTROL) begin
        if (wmask[hc_port_pkg::POS_PORT_POWER_ON])
          ctrl_q.port_power_on <= wval[hc_port_pkg::POS_PORT_POWER_ON];
        if (pwr) begin
          if (wmask[hc_port_pkg::POS_TEST_SELECT_LO])
            ctrl_q.test_select <= wval[hc_port_pkg::POS_TEST_SELECT_LO +: 4];
          if (wmask[hc_port_pkg::POS_BUS_RESET_DRIVE])
            ctrl_q.bus_reset_drive <= wval[hc_port_pkg::POS_BUS_RESET_DRIVE];
          if (wmask[hc_port_pkg::POS_PORT_ENABLE]) begin
            ctrl_q.port_suspended  <= wval[hc_port_pkg::POS_PORT_SUSPENDED];
            ctrl_q.force_resume_sw <= wval[hc_port_pkg::POS_FORCE_RESUME];
            ctrl_q.port_enable     <= wval[hc_port_pkg::POS_PORT_ENABLE] & pins_q.connect;
          end
        end
      end
      // Change flag: a new change wins over a clear in the same cycle
      if (pins_q.connect != pins_prev_q.connect) ctrl_q.connect_change <= 1'b1;
      else if (wr_fire && wr_idx == hc_port_pkg::IDX_PORT_STATUS_CONTROL && pwr
               && wmask[hc_port_pkg::POS_CONNECT_CHANGE] && wval[hc_port_pkg::POS_CONNECT_CHANGE])
        ctrl_q.connect_change <= 1'b0;
      if (!pins_q.connect) ctrl_q.port_enable <= 1'b0;
    end
  end

  always_comb begin
    port_word = '0;
    port_word[hc_port_pkg::POS_TEST_SELECT_LO +: 4] = ctrl_q.test_select;
    port_word[hc_port_pkg::POS_HANDOFF_OWNER]  = ctrl_q.handoff_owner;
    port_word[hc_port_pkg::POS_PORT_POWER_ON]  = pwr;
    port_word[hc_port_pkg::POS_LINE_STATE_DP]  = pins_q.dp;
    port_word[hc_port_pkg::POS_LINE_STATE_DM]  = pins_q.dm;
    port_word[hc_port_pkg::POS_BUS_RESET_DRIVE] = pwr & ctrl_q.bus_reset_drive;
    port_word[hc_port_pkg::POS_PORT_SUSPENDED] = pwr & (ctrl_q.port_suspended | pins_q.suspended);
    port_word[hc_port_pkg::POS_FORCE_RESUME]   = pwr & (ctrl_q.force_resume_sw | pins_q.resume_k);
    port_word[hc_port_pkg::POS_PORT_ENABLE]    = pwr & ctrl_q.port_enable;
    port_word[hc_port_pkg::POS_CONNECT_CHANGE] = pwr & ctrl_q.connect_change;
    port_word[hc_port_pkg::POS_CONNECT_PRESENT] = pwr & pins_q.connect;
  end

  // Read channel
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  always_comb begin
    rd_idx   = s_axi_araddr[9:2];
    rd_known = 1'b1;
    rd_word  = '0;
    case (rd_idx)
      hc_port_pkg::IDX_PORT_STATUS_CONTROL: rd_word = port_word;
      hc_port_pkg::IDX_ISO_DONE_MAP:        rd_word[NUM_DESC-1:0] = iso_done_q;
      hc_port_pkg::IDX_ISO_SKIP_MAP:        rd_word[NUM_DESC-1:0] = iso_skip_q;
      hc_port_pkg::IDX_ISO_LAST_MAP:        rd_word[NUM_DESC-1:0] = iso_last_q;
      hc_port_pkg::IDX_INTERRUPT_DONE_MAP:  rd_word[NUM_DESC-1:0] = int_done_q;
      hc_port_pkg::IDX_CONFIGURE_FLAG_REG:  rd_word[0] = cfg_flag_q;
      hc_port_pkg::IDX_SCAN_STATUS:         rd_word[4:0] = {iso_process, scan_idx_q};
      default:                              rd_known = 1'b0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= hc_port_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_known ? hc_port_pkg::RESP_OKAY : hc_port_pkg::RESP_SLVERR;
        s_axi_arready <= 1'b0;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Done maps: completion in the reading cycle survives the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      iso_done_q <= hc_port_pkg::RESET_DONE_MAP;
      int_done_q <= hc_port_pkg::RESET_DONE_MAP;
    end else if (clk_en) begin
      iso_done_q <= (iso_done_q & ~((rd_fire && rd_idx == hc_port_pkg::IDX_ISO_DONE_MAP) ? iso_done_q : '0))
                    | iso_complete;
      int_done_q <= (int_done_q & ~((rd_fire && rd_idx == hc_port_pkg::IDX_INTERRUPT_DONE_MAP) ? int_done_q : '0))
                    | int_complete;
    end
  end

  // Skip and last maps written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      iso_skip_q <= hc_port_pkg::RESET_SKIP_MAP;
      iso_last_q <= hc_port_pkg::RESET_LAST_MAP;
    end else if (clk_en && wr_fire) begin
      if (wr_idx == hc_port_pkg::IDX_ISO_SKIP_MAP)
        iso_skip_q <= (iso_skip_q & ~wmask[NUM_DESC-1:0]) | wval[NUM_DESC-1:0];
      if (wr_idx == hc_port_pkg::IDX_ISO_LAST_MAP)
        iso_last_q <= (iso_last_q & ~wmask[NUM_DESC-1:0]) | wval[NUM_DESC-1:0];
    end
  end

  // Scan pointer: ascending, wraps after the last-marked descriptor or the top
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_idx_q <= 4'h0;
    end else if (clk_en && iso_scan_step) begin
      if (iso_last_q[scan_idx_q] || scan_idx_q == 4'(NUM_DESC - 1)) scan_idx_q <= 4'h0;
      else scan_idx_q <= scan_idx_q + 4'h1;
    end
  end

  // Registered outputs toward the port and the engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      root_hub_enable   <= 1'b0;
      bus_reset_out     <= 1'b0;
      test_mode         <= hc_port_pkg::RESET_TEST_SELECT;
      handoff_owner_out <= 1'b1;
      iso_process       <= 1'b0;
      iso_process_index <= 4'h0;
    end else if (clk_en) begin
      root_hub_enable   <= pwr;
      bus_reset_out     <= pwr & ctrl_q.bus_reset_drive;
      test_mode         <= ctrl_q.test_select;
      handoff_owner_out <= ctrl_q.handoff_owner;
      iso_process       <= iso_valid[scan_idx_q] & ~iso_skip_q[scan_idx_q];
      iso_process_index <= scan_idx_q;
    end
  end

  a_done_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && rd_fire && rd_idx == hc_port_pkg::IDX_ISO_DONE_MAP && iso_complete == '0)
    |=> (iso_done_q == '0)) else $error("done map not cleared by read");
  a_done_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && iso_complete[0]) |=> iso_done_q[0]) else $error("done bit not set");
  a_skip_block: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && iso_skip_q[scan_idx_q]) |=> !iso_process) else $error("skipped descriptor processed");
  a_nopower_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    !pwr |-> (port_word[8:0] == '0)) else $error("status bits not zero without power");
  // Checked in the same cycle: the flag rise clears the owner at the very edge that sets the flag
  a_owner_forced: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg_flag_q |-> ctrl_q.handoff_owner) else $error("owner not forced high");
  a_owner_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && $rose(cfg_flag_q)) |-> !ctrl_q.handoff_owner) else $error("owner not cleared on flag rise");
  a_power_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !pwr |=> $stable(ctrl_q.bus_reset_drive)) else $error("port state changed without power");
  a_change: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && pins_q.connect != pins_prev_q.connect) |=> ctrl_q.connect_change) else $error("change not flagged");
  a_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && iso_scan_step && iso_last_q[scan_idx_q]) |=> scan_idx_q == 4'h0) else $error("scan did not wrap");
  a_reset_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && pwr && ctrl_q.bus_reset_drive) |=> bus_reset_out) else $error("bus reset not driven");
endmodule
`default_nettype wire

// ---- tb/usb_peer_model.sv ----
// Purpose: Peripheral on the root-hub port, seen only as PHY pin levels
// Assumes: Full-speed peer idling in J; line pulled down while detached
// Notes:   Status pins for enable and suspend are left low by the peer
`timescale 1ns/1ps
`default_nettype none
module usb_peer_model (
  input  wire logic                       attach,
  input  wire logic                       resume,
  input  wire logic                       bus_reset_out,
  output var  hc_port_pkg::port_pins_type port_pins
);
  always_comb begin
    port_pins.connect   = attach;
    port_pins.suspended = 1'h0;
    port_pins.enabled   = 1'h0;
    port_pins.resume_k  = attach & resume;
    if (!attach) begin
      {port_pins.dp, port_pins.dm} = 2'h0;
    end else if (bus_reset_out) begin
      {port_pins.dp, port_pins.dm} = 2'h0;
    end else if (resume) begin
      {port_pins.dp, port_pins.dm} = 2'h1;
    end else begin
      {port_pins.dp, port_pins.dm} = 2'h2;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the port word and descriptor maps
// Assumes: Power settle shortened to a few cycles to keep the run short
// Notes:   Register access through AXI4-Lite tasks with bounded waits
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [9:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] iso_valid = '0, iso_complete = '0, int_complete = '0;
  logic        iso_scan_step = 1'h0, attach = 1'h0, resume = 1'h0, clk_en = 1'h1;
  logic        root_hub_enable, bus_reset_out, handoff_owner_out, iso_process;
  logic [3:0]  test_mode, iso_process_index;
  hc_port_pkg::port_pins_type port_pins;
  int          error_cnt = 0, comparisons = 0;
  localparam logic [9:0] A_PORT = {hc_port_pkg::IDX_PORT_STATUS_CONTROL, 2'h0};
  localparam logic [9:0] A_IDONE = {hc_port_pkg::IDX_ISO_DONE_MAP, 2'h0};
  localparam logic [9:0] A_SKIP = {hc_port_pkg::IDX_ISO_SKIP_MAP, 2'h0};
  localparam logic [9:0] A_LAST = {hc_port_pkg::IDX_ISO_LAST_MAP, 2'h0};
  localparam logic [9:0] A_NDONE = {hc_port_pkg::IDX_INTERRUPT_DONE_MAP, 2'h0};
  localparam logic [9:0] A_CFG = {hc_port_pkg::IDX_CONFIGURE_FLAG_REG, 2'h0};
  localparam logic [9:0] A_SCAN = {hc_port_pkg::IDX_SCAN_STATUS, 2'h0};

  hc_port_regs #(.NUM_DESC(16)) i_dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .port_pins, .iso_valid, .iso_complete, .int_complete, .iso_scan_step, .root_hub_enable,
    .bus_reset_out, .test_mode, .handoff_owner_out, .iso_process, .iso_process_index);
  usb_peer_model i_peer (.attach, .resume, .bus_reset_out, .port_pins);

  initial forever #10 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Both channels offered together; each released on its own handshake
  task automatic axi_wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 50);
    s_axi_bready <= 1'h0;
    r = s_axi_bresp;
    if (n >= 50) chk(32'h0, 32'h1, "write response missing");
  endtask

  task automatic axi_rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 50);
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n >= 50) chk(32'h0, 32'h1, "read response missing");
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk(32'(r), 32'(hc_port_pkg::RESP_OKAY), "write response");
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk(d, exp, what);
    chk(32'(r), 32'(hc_port_pkg::RESP_OKAY), "read response");
  endtask

  // Pins pass a two-flop synchroniser, so give them a few cycles
  task automatic settle();
    repeat (4) @(posedge aclk);
  endtask

  task automatic step();
    @(posedge aclk);
    iso_scan_step <= 1'h1;
    @(posedge aclk);
    iso_scan_step <= 1'h0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic t_defaults();
    logic [31:0] d;
    logic [1:0]  r;
    rd(A_PORT, 32'h2000, "port reset");
    rd(A_SKIP, 32'hffff, "skip reset");
    rd(A_LAST, 32'h0, "last reset");
    rd(A_IDONE, 32'h0, "iso done reset");
    rd(A_NDONE, 32'h0, "int done reset");
    axi_rd(10'h3fc, d, r);
    chk(d, 32'h0, "unmapped read data");
    chk(32'(r), 32'(hc_port_pkg::RESP_SLVERR), "unmapped read");
    axi_wr(10'h3fc, 32'h1, r);
    chk(32'(r), 32'(hc_port_pkg::RESP_SLVERR), "unmapped write");
    chk(32'({root_hub_enable, handoff_owner_out}), 32'h1, "outputs after reset");
    $display("test defaults done");
  endtask

  task automatic t_power();
    attach <= 1'h1;
    settle();
    rd(A_PORT, 32'h2800, "unpowered port");
    wr(A_PORT, 32'h0104);
    settle();
    chk(32'(bus_reset_out), 32'h0, "reset without power");
    rd(A_PORT, 32'h2800, "write ignored unpowered");
    wr(A_PORT, 32'h1000);
    settle();
    chk(32'(root_hub_enable), 32'h1, "root hub on");
    rd(A_PORT, 32'h3803, "attach seen");
    wr(A_PORT, 32'h1002);
    rd(A_PORT, 32'h3801, "change cleared");
    attach <= 1'h0;
    settle();
    rd(A_PORT, 32'h3002, "detach seen");
    attach <= 1'h1;
    settle();
    wr(A_PORT, 32'h1002);
    rd(A_PORT, 32'h3801, "attached again");
    $display("test power done");
  endtask

  task automatic t_portops();
    wr(A_PORT, 32'h1100);
    settle();
    chk(32'(bus_reset_out), 32'h1, "bus reset driven");
    rd(A_PORT, 32'h3101, "bus reset reads");
    wr(A_PORT, 32'h1000);
    settle();
    chk(32'(bus_reset_out), 32'h0, "bus reset ended");
    wr(A_PORT, 32'h1004);
    rd(A_PORT, 32'h3805, "enabled");
    wr(A_PORT, 32'h1084);
    rd(A_PORT, 32'h3885, "suspended");
    resume <= 1'h1;
    settle();
    rd(A_PORT, 32'h34c5, "resume K");
    resume <= 1'h0;
    wr(A_PORT, 32'h1004);
    settle();
    rd(A_PORT, 32'h3805, "resume gone");
    for (int t = 15; t >= 0; t--) begin
      wr(A_PORT, 32'h1004 | (t << 16));
      @(posedge aclk);
      chk(32'(test_mode), t, "test mode");
    end
    $display("test port operations done");
  endtask

  task automatic t_owner();
    wr(A_CFG, 32'h1);
    settle();
    chk(32'(handoff_owner_out), 32'h0, "owner on flag rise");
    rd(A_PORT, 32'h1805, "owner bit cleared");
    wr(A_CFG, 32'h0);
    settle();
    chk(32'(handoff_owner_out), 32'h1, "owner with flag low");
    wr(A_PORT, 32'h0);
    settle();
    chk(32'(root_hub_enable), 32'h0, "root hub off");
    rd(A_PORT, 32'h2800, "status masked");
    $display("test owner done");
  endtask

  task automatic t_done();
    // A completion while the clock enable is low must be lost
    @(posedge aclk);
    clk_en       <= 1'h0;
    iso_complete <= 16'h0010;
    @(posedge aclk);
    clk_en       <= 1'h1;
    iso_complete <= 16'h0005;
    int_complete <= 16'h8001;
    @(posedge aclk);
    iso_complete <= 16'h0;
    int_complete <= 16'h0;
    rd(A_IDONE, 32'h0005, "iso done");
    rd(A_IDONE, 32'h0, "iso done cleared");
    rd(A_NDONE, 32'h8001, "int done");
    rd(A_NDONE, 32'h0, "int done cleared");
    @(posedge aclk);
    iso_complete <= 16'h8000;
    @(posedge aclk);
    iso_complete <= 16'h0;
    rd(A_IDONE, 32'h8000, "later completion");
    $display("test done maps done");
  endtask

  task automatic t_scan();
    int n;
    int e;
    iso_valid <= 16'hffff;
    chk(32'(iso_process_index), 32'h0, "scan start");
    wr(A_SKIP, 32'hfffa);
    repeat (hc_port_pkg::SKIP_READBACK_CYCLES) @(posedge aclk);
    rd(A_SKIP, 32'hfffa, "skip readback");
    for (int k = 0; k < 3; k++) begin
      wr(A_LAST, 32'h1 << k);
      n = 0;
      while (iso_process_index !== 4'h0 && n < 20) begin
        step();
        n++;
      end
      for (int j = 1; j <= k + 1; j++) begin
        step();
        e = j % (k + 1);
        chk(32'(iso_process_index), e, "scan index");
        chk(32'(iso_process), 32'(e != 1), "skip honoured");
      end
    end
    rd(A_SCAN, 32'h10, "scan status");
    $display("test scan done");
  endtask

  task automatic t_reset2();
    // Leave state that the reset must undo
    wr(A_PORT, 32'h1004);
    wr(A_CFG, 32'h1);
    wr(A_SKIP, 32'h0);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk(32'({root_hub_enable, handoff_owner_out}), 32'h1, "outputs after second reset");
    rd(A_PORT, 32'h2800, "port after second reset");
    rd(A_CFG, 32'h0, "flag after second reset");
    rd(A_SKIP, 32'hffff, "skip after second reset");
    $display("test second reset done");
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done();
  end

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    t_defaults();
    t_scan();
    t_power();
    t_portops();
    t_owner();
    t_done();
    t_reset2();
    test_done();
  end
endmodule
`default_nettype wire
